// [rtl/ufesc_pkg.sv]
// Shared constants and types for the frame, pull-up and EP0 stall block.
package ufesc_pkg;

  typedef logic [31:0] ufesc_addr_t;
  typedef logic [15:0] ufesc_data_t;

  // Register addresses.
  localparam ufesc_addr_t UFESC_FNH_ADDR    = 32'h5000_1824;
  localparam ufesc_addr_t UFESC_FNL_ADDR    = 32'h5000_1826;
  localparam ufesc_addr_t UFESC_PUTEST_ADDR = 32'h5000_183e;
  localparam ufesc_addr_t UFESC_EP0_ADDR    = 32'h5000_1840;
  localparam ufesc_addr_t UFESC_STAT_ADDR   = 32'h5000_18f0;
  localparam ufesc_addr_t UFESC_MASK_ADDR   = 32'h5000_18f2;

  // Frame number layout.
  localparam int UFESC_FN_W      = 11;
  localparam int UFESC_FN_LOW_W  = 8;
  localparam int UFESC_FN_HIGH_W = 3;

  // Pull-up test control fields.
  localparam int UFESC_PU_TEST_C_BIT  = 7;
  localparam int UFESC_PU_SW2_BIT     = 6;
  localparam int UFESC_PU_SW1_BIT     = 5;
  localparam int UFESC_PU_EN_BIT      = 4;
  localparam int UFESC_PU_SW1DM_BIT   = 2;
  localparam int UFESC_PU_TEST_A_BIT  = 1;
  localparam int UFESC_PU_TEST_B_BIT  = 0;
  localparam ufesc_data_t UFESC_PU_WMASK = 16'h0077;

  // Endpoint-0 control fields.
  localparam int UFESC_EP0_HALT_BIT = 7;

  // Interrupt event bits.
  localparam int UFESC_EVT_W         = 4;
  localparam int UFESC_EVT_IN_STALL  = 0;
  localparam int UFESC_EVT_OUT_STALL = 1;
  localparam int UFESC_EVT_SENT      = 2;
  localparam int UFESC_EVT_SETUP     = 3;

  // Values after reset.
  localparam ufesc_data_t UFESC_PU_RST    = 16'h0000;
  localparam logic        UFESC_HALT_RST  = 1'b0;
  localparam logic [UFESC_EVT_W-1:0] UFESC_EVT_RST = 4'h0;
  localparam ufesc_data_t UFESC_ZERO      = 16'h0000;

  typedef enum logic [1:0] {
    UFESC_TOK_OUT   = 2'h0,
    UFESC_TOK_IN    = 2'h1,
    UFESC_TOK_SETUP = 2'h2,
    UFESC_TOK_SOF   = 2'h3
  } ufesc_tok_e;

  typedef enum logic [2:0] {
    UFESC_ST_IDLE = 3'b001,
    UFESC_ST_WAIT = 3'b010,
    UFESC_ST_DONE = 3'b100
  } ufesc_state_e;

endpackage : ufesc_pkg

// [rtl/ufesc_irq_if.sv]
// Interface between the register block and the sticky interrupt logic.
`timescale 1ns/100ps
interface ufesc_irq_if;
  import ufesc_pkg::*;
  logic [UFESC_EVT_W-1:0] evt_set;
  logic                   stat_rd_clr;
  logic                   mask_we;
  logic [UFESC_EVT_W-1:0] mask_wdata;
  logic [UFESC_EVT_W-1:0] status;
  logic [UFESC_EVT_W-1:0] mask;
  logic                   irq;

  modport regs (output evt_set, stat_rd_clr, mask_we, mask_wdata,
                input  status, mask, irq);
  modport sticky (input  evt_set, stat_rd_clr, mask_we, mask_wdata,
                  output status, mask, irq);
endinterface : ufesc_irq_if

// [rtl/ufesc_irq.sv]
// Sticky event status, mask and level interrupt.
`timescale 1ns/100ps
module ufesc_irq (
  input wire logic    clk,
  input wire logic    rst_n,
  ufesc_irq_if.sticky bus
);
  import ufesc_pkg::*;

  logic [UFESC_EVT_W-1:0] status_reg;
  logic [UFESC_EVT_W-1:0] status_next;
  logic [UFESC_EVT_W-1:0] mask_reg;
  logic                   irq_reg;

  // A new event in the clearing read cycle survives the clear.
  assign status_next = (bus.stat_rd_clr ? UFESC_EVT_RST : status_reg)
                       | bus.evt_set;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= UFESC_EVT_RST;
      mask_reg   <= UFESC_EVT_RST;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (bus.mask_we) begin
        mask_reg <= bus.mask_wdata;
      end
      irq_reg <= |(status_next & (bus.mask_we ? bus.mask_wdata : mask_reg));
    end
  end

  assign bus.status = status_reg;
  assign bus.mask   = mask_reg;
  assign bus.irq    = irq_reg;
endmodule : ufesc_irq

// [rtl/ufesc_fn_latch.sv]
// Holds the upper frame-number bits between a low-byte and a high read.
`timescale 1ns/100ps
module ufesc_fn_latch (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic [ufesc_pkg::UFESC_FN_HIGH_W-1:0] live_high,
  input  wire logic                                 low_read,
  input  wire logic                                 high_read,
  output logic      [ufesc_pkg::UFESC_FN_HIGH_W-1:0] view_high
);
  import ufesc_pkg::*;

  logic [UFESC_FN_HIGH_W-1:0] hold_reg;
  logic                       locked_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg   <= 3'h0;
      locked_reg <= 1'b0;
    end else if (low_read) begin
      hold_reg   <= live_high;
      locked_reg <= 1'b1;
    end else if (high_read) begin
      locked_reg <= 1'b0;
    end
  end

  // Without a preceding low read the live bits are shown.
  assign view_high = locked_reg ? hold_reg : live_high;
endmodule : ufesc_fn_latch

// [rtl/ufesc_top.sv]
// Frame-number read port, pull-up test control and endpoint-0 stall logic.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
// Function
// - Low frame register shows frame bits 7:0.
// - Low-byte read freezes high bits until high read.
// - High register holds top three frame bits.
// - High read without low read shows live bits.
// - Test enable bit 4 activates switch bits.
// - Bit 6 zero closes reduced pull-up switch.
// - Bit 5 zero enables plus-line pull-up.
// - Bit 2 zero enables minus-line pull-up.
// - Halt plus transmit enable stalls IN tokens.
// - Halt plus receive enable stalls OUT tokens.
// - SETUP tokens never get a STALL.
// - After STALL set receive-last and transmit-done flags.
module ufesc_top (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire ufesc_pkg::ufesc_addr_t   addr,
  input  wire ufesc_pkg::ufesc_data_t   wr_data,
  input  wire logic                     wr_en,
  input  wire logic                     rd_en,
  output ufesc_pkg::ufesc_data_t        rd_data,
  input  wire logic [10:0]              frame_number,
  input  wire logic                     token_valid,
  input  wire ufesc_pkg::ufesc_tok_e    token_kind,
  input  wire logic                     tx_fifo_en,
  input  wire logic                     rx_fifo_en,
  input  wire logic                     stall_sent,
  input  wire logic                     normal_dp_pullup_en,
  input  wire logic                     normal_dm_pullup_en,
  input  wire logic                     normal_reduced_pullup_en,
  output logic                          stall_req,
  output logic                          rx_last_set,
  output logic                          tx_done_set,
  output logic                          dp_pullup_en,
  output logic                          dm_pullup_en,
  output logic                          reduced_pullup_en,
  output logic                          irq
);
  import ufesc_pkg::*;

  // Reset release synchroniser.
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_sync_n = rst_sync_reg;

  // Address decode.
  wire sel_fnh  = (addr == UFESC_FNH_ADDR);
  wire sel_fnl  = (addr == UFESC_FNL_ADDR);
  wire sel_pu   = (addr == UFESC_PUTEST_ADDR);
  wire sel_ep0  = (addr == UFESC_EP0_ADDR);
  wire sel_stat = (addr == UFESC_STAT_ADDR);
  wire sel_mask = (addr == UFESC_MASK_ADDR);

  wire rd_fnl  = rd_en && sel_fnl;
  wire rd_fnh  = rd_en && sel_fnh;
  wire rd_stat = rd_en && sel_stat;
  wire wr_pu   = wr_en && sel_pu;
  wire wr_ep0  = wr_en && sel_ep0;
  wire wr_mask = wr_en && sel_mask;

  // Software-visible control registers.
  ufesc_data_t pu_ctl_reg;
  logic        halt_reg;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pu_ctl_reg <= UFESC_PU_RST;
      halt_reg   <= UFESC_HALT_RST;
    end else begin
      if (wr_pu) begin
        // Bit 7 is read-only and reserved bits are not stored.
        pu_ctl_reg <= wr_data & UFESC_PU_WMASK;
      end
      if (wr_ep0) begin
        halt_reg <= wr_data[UFESC_EP0_HALT_BIT];
      end
    end
  end

  // Frame number coherence.
  logic [UFESC_FN_HIGH_W-1:0] fn_high_view;

  ufesc_fn_latch u_fn_latch (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .live_high (frame_number[UFESC_FN_W-1:UFESC_FN_LOW_W]),
    .low_read  (rd_fnl),
    .high_read (rd_fnh),
    .view_high (fn_high_view)
  );

  // Pull-up switch control.
  wire pu_test = pu_ctl_reg[UFESC_PU_EN_BIT];
  wire dp_pu_next  = pu_test ? ~pu_ctl_reg[UFESC_PU_SW1_BIT]
                             : normal_dp_pullup_en;
  wire dm_pu_next  = pu_test ? ~pu_ctl_reg[UFESC_PU_SW1DM_BIT]
                             : normal_dm_pullup_en;
  wire red_pu_next = pu_test ? ~pu_ctl_reg[UFESC_PU_SW2_BIT]
                             : normal_reduced_pullup_en;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dp_pullup_en      <= 1'b0;
      dm_pullup_en      <= 1'b0;
      reduced_pullup_en <= 1'b0;
    end else begin
      dp_pullup_en      <= dp_pu_next;
      dm_pullup_en      <= dm_pu_next;
      reduced_pullup_en <= red_pu_next;
    end
  end

  // Stall handshake sequencing.
  ufesc_state_e state_reg;
  ufesc_state_e state_next;

  wire is_in    = token_valid && (token_kind == UFESC_TOK_IN);
  wire is_out   = token_valid && (token_kind == UFESC_TOK_OUT);
  wire is_setup = token_valid && (token_kind == UFESC_TOK_SETUP);
  wire idle     = (state_reg == UFESC_ST_IDLE);
  wire take_in  = idle && is_in && halt_reg && tx_fifo_en;
  wire take_out = idle && is_out && halt_reg && rx_fifo_en;
  // A SETUP token never starts a stall, halted or not.
  wire setup_halted = is_setup && halt_reg;
  wire stall_take   = take_in || take_out;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      UFESC_ST_IDLE: begin
        if (stall_take) begin
          state_next = UFESC_ST_WAIT;
        end
      end
      UFESC_ST_WAIT: begin
        if (stall_sent) begin
          state_next = UFESC_ST_DONE;
        end
      end
      UFESC_ST_DONE: begin
        state_next = UFESC_ST_IDLE;
      end
      default: begin
        state_next = UFESC_ST_IDLE;
      end
    endcase
  end

  wire done_next = (state_next == UFESC_ST_DONE);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg   <= UFESC_ST_IDLE;
      stall_req   <= 1'b0;
      rx_last_set <= 1'b0;
      tx_done_set <= 1'b0;
    end else begin
      state_reg   <= state_next;
      stall_req   <= (state_next == UFESC_ST_WAIT);
      rx_last_set <= done_next;
      tx_done_set <= done_next;
    end
  end

  // Interrupt status and mask.
  ufesc_irq_if irq_bus ();

  assign irq_bus.evt_set = {setup_halted,
                            (state_reg == UFESC_ST_WAIT) && stall_sent,
                            take_out,
                            take_in};
  assign irq_bus.stat_rd_clr = rd_stat;
  assign irq_bus.mask_we     = wr_mask;
  assign irq_bus.mask_wdata  = wr_data[UFESC_EVT_W-1:0];
  assign irq                 = irq_bus.irq;

  ufesc_irq u_irq (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .bus   (irq_bus)
  );

  // Read data mux; unmapped addresses read zero.
  wire ufesc_data_t fnl_view  =
      {8'h00, frame_number[UFESC_FN_LOW_W-1:0]};
  wire ufesc_data_t fnh_view  = {13'h0000, fn_high_view};
  wire ufesc_data_t ep0_view  = {8'h00, halt_reg, 7'h00};
  wire ufesc_data_t stat_view = {12'h000, irq_bus.status};
  wire ufesc_data_t mask_view = {12'h000, irq_bus.mask};

  wire ufesc_data_t rd_mux =
      sel_fnl  ? fnl_view   :
      sel_fnh  ? fnh_view   :
      sel_pu   ? pu_ctl_reg :
      sel_ep0  ? ep0_view   :
      sel_stat ? stat_view  :
      sel_mask ? mask_view  : UFESC_ZERO;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data <= UFESC_ZERO;
    end else if (rd_en) begin
      rd_data <= rd_mux;
    end else begin
      rd_data <= UFESC_ZERO;
    end
  end

endmodule : ufesc_top

// [sim/ufesc_host_model.sv]
// Host side model: sends tokens and reports STALL handshakes as sent.
`timescale 1ns/100ps
module ufesc_host_model (
  input  wire logic                  clk,
  input  wire logic                  go,
  input  wire ufesc_pkg::ufesc_tok_e kind,
  input  wire logic [3:0]            delay,
  input  wire logic                  stall_req,
  output logic                       token_valid,
  output ufesc_pkg::ufesc_tok_e      token_kind,
  output logic                       stall_sent
);
  import ufesc_pkg::*;
  logic [3:0] wait_reg;
  initial begin
    token_valid = 1'b0;
    token_kind  = UFESC_TOK_SOF;
    stall_sent  = 1'b0;
    wait_reg    = 4'h0;
  end
  // Kind wanders between tokens so a stale value is never trusted.
  always @(posedge clk) begin
    token_valid <= go;
    token_kind  <= go ? kind : ufesc_tok_e'(token_kind + 2'h1);
    stall_sent  <= 1'b0;
    if (!stall_req || stall_sent) begin
      wait_reg <= delay;
    end else if (wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end else begin
      stall_sent <= 1'b1;
    end
  end
endmodule : ufesc_host_model

// [sim/ufesc_top_asserts.sv]
// Port level checks for the frame, pull-up and stall block.
`timescale 1ns/100ps
module ufesc_top_asserts (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [31:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] rd_data,
  input wire logic [10:0] frame_number,
  input wire logic        token_valid,
  input wire ufesc_pkg::ufesc_tok_e token_kind,
  input wire logic        tx_fifo_en,
  input wire logic        rx_fifo_en,
  input wire logic        stall_sent,
  input wire logic        normal_dp_pullup_en,
  input wire logic        normal_dm_pullup_en,
  input wire logic        normal_reduced_pullup_en,
  input wire logic        stall_req,
  input wire logic        rx_last_set,
  input wire logic        tx_done_set,
  input wire logic        dp_pullup_en,
  input wire logic        dm_pullup_en,
  input wire logic        reduced_pullup_en
);
  import ufesc_pkg::*;
  logic       halt_reg;
  logic       lock_reg;
  logic [2:0] lock_hi_reg;
  logic [6:0] pu_reg;
  wire        idle   = !stall_req && !tx_done_set;
  wire        fnl_rd = rd_en && addr == UFESC_FNL_ADDR;
  wire        fnh_rd = rd_en && addr == UFESC_FNH_ADDR;
  wire [7:0]  fn_lo  = frame_number[7:0];
  wire [2:0]  hi_exp = lock_reg ? lock_hi_reg : frame_number[10:8];
  wire [2:0]  pu_out = {dp_pullup_en, dm_pullup_en, reduced_pullup_en};
  wire [2:0]  pu_exp = pu_reg[4] ? ~{pu_reg[5], pu_reg[2], pu_reg[6]} :
    {normal_dp_pullup_en, normal_dm_pullup_en, normal_reduced_pullup_en};
  wire        in_ok  = token_kind == UFESC_TOK_IN && tx_fifo_en;
  wire        out_ok = token_kind == UFESC_TOK_OUT && rx_fifo_en;
  wire        stl_ok = token_valid && idle && halt_reg && (in_ok || out_ok);
  // Shadows of the halt bit, the pull-up field and the frame lock.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_reg    <= 1'b0;
      lock_reg    <= 1'b0;
      lock_hi_reg <= 3'h0;
      pu_reg      <= 7'h00;
    end else begin
      halt_reg    <= (wr_en && addr == UFESC_EP0_ADDR) ? wr_data[7] : halt_reg;
      pu_reg      <= (wr_en && addr == UFESC_PUTEST_ADDR) ?
                     wr_data[6:0] & 7'h77 : pu_reg;
      lock_reg    <= fnl_rd | (lock_reg & !fnh_rd);
      lock_hi_reg <= fnl_rd ? frame_number[10:8] : lock_hi_reg;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_IN_STALL: assert property (
    token_valid && idle && halt_reg && in_ok |=> stall_req)
    else $error("IN token not stalled");
  AST_OUT_STALL: assert property (
    token_valid && idle && halt_reg && out_ok |=> stall_req)
    else $error("OUT token not stalled");
  AST_SETUP_FREE: assert property (
    token_valid && idle && token_kind == UFESC_TOK_SETUP |=> !stall_req)
    else $error("SETUP token stalled");
  AST_STALL_CAUSE: assert property (
    $rose(stall_req) |-> $past(stl_ok))
    else $error("stall without cause");
  AST_STALL_HOLD: assert property (
    stall_req && !stall_sent |=> stall_req)
    else $error("stall request dropped early");
  AST_STALL_DONE: assert property (
    stall_req && stall_sent |=> !stall_req && rx_last_set && tx_done_set
    ##1 !rx_last_set && !tx_done_set)
    else $error("flags not pulsed after stall");
  AST_FNL_VIEW: assert property (
    fnl_rd |=> rd_data == {8'h00, $past(fn_lo)})
    else $error("low frame byte wrong");
  AST_FNH_VIEW: assert property (
    fnh_rd |=> rd_data == {13'h0000, $past(hi_exp)})
    else $error("high frame bits wrong");
  AST_PULLUP: assert property (
    pu_out == $past(pu_exp))
    else $error("pull-up enables wrong");
  cover property (stall_req && stall_sent);
  cover property (fnh_rd && lock_reg);
  cover property (pu_reg[4] && !pu_reg[5]);
endmodule : ufesc_top_asserts

bind ufesc_top ufesc_top_asserts u_asserts (.*);

// [sim/testbench.sv]
// Self-checking bench for the frame, pull-up and stall block.
`timescale 1ns/100ps
module testbench;
  import ufesc_pkg::*;
  logic        clk;
  logic        rst_n;
  ufesc_addr_t addr;
  ufesc_data_t wr_data;
  ufesc_data_t rd_data;
  logic        wr_en;
  logic        rd_en;
  logic [10:0] frame_number;
  logic        token_valid;
  ufesc_tok_e  token_kind;
  logic        tx_en;
  logic        rx_en;
  logic        stall_sent;
  logic        stall_req;
  logic        rx_last_set;
  logic        tx_done_set;
  logic        irq;
  logic        go;
  ufesc_tok_e  kind;
  logic [3:0]  delay;
  logic [2:0]  npu;
  logic [2:0]  pu;
  int          err_count;
  int          n_checks;

  ufesc_top DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .frame_number(frame_number), .token_valid(token_valid),
    .token_kind(token_kind), .tx_fifo_en(tx_en), .rx_fifo_en(rx_en),
    .stall_sent(stall_sent), .normal_dp_pullup_en(npu[2]),
    .normal_dm_pullup_en(npu[1]), .normal_reduced_pullup_en(npu[0]),
    .stall_req(stall_req), .rx_last_set(rx_last_set),
    .tx_done_set(tx_done_set), .dp_pullup_en(pu[2]),
    .dm_pullup_en(pu[1]), .reduced_pullup_en(pu[0]), .irq(irq));
  ufesc_host_model host (.clk(clk), .go(go), .kind(kind), .delay(delay),
    .stall_req(stall_req), .token_valid(token_valid),
    .token_kind(token_kind), .stall_sent(stall_sent));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input ufesc_data_t got, input ufesc_data_t exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_pu(input logic [2:0] exp);
    #1 chk({13'h0000, pu}, {13'h0000, exp});
  endtask : chk_pu

  task automatic wr(input ufesc_addr_t a, input ufesc_data_t d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input ufesc_addr_t a, input ufesc_data_t e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rd_data, e);
  endtask : rd

  // Sends one token and checks against e whether a completed stall followed within 20 cycles.
  task automatic tok(input ufesc_tok_e k, input logic [3:0] d,
                     input logic e);
    logic seen;
    seen = 1'b0;
    @(posedge clk);
    go    <= 1'b1;
    kind  <= k;
    delay <= d;
    @(posedge clk);
    go    <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      #1 seen = seen | (rx_last_set & tx_done_set);
    end
    chk({15'h0000, seen}, {15'h0000, e});
  endtask : tok

  task automatic t_frame();
    rd(UFESC_PUTEST_ADDR, 16'h0000);
    rd(32'h5000_1830, 16'h0000);
    @(posedge clk);
    frame_number <= 11'h5a3;
    rd(UFESC_FNL_ADDR, 16'h00a3);
    @(posedge clk);
    frame_number <= 11'h2c4;
    rd(UFESC_FNH_ADDR, 16'h0005);
    rd(UFESC_FNH_ADDR, 16'h0002);
    wr(UFESC_FNL_ADDR, 16'hffff);
    rd(UFESC_FNL_ADDR, 16'h00c4);
  endtask : t_frame

  task automatic t_pullup();
    ufesc_data_t w[5] = '{16'h0000, 16'h0070, 16'h0014, 16'h0030, 16'h0054};
    logic [2:0]  e[5] = '{3'b001, 3'b010, 3'b101, 3'b011, 3'b100};
    wr(UFESC_PUTEST_ADDR, 16'hfff4);
    rd(UFESC_PUTEST_ADDR, 16'h0074);
    for (int i = 0; i < 5; i++) begin
      wr(UFESC_PUTEST_ADDR, w[i]);
      @(posedge clk);
      chk_pu(e[i]);
    end
    @(posedge clk);
    npu <= 3'b110;
    repeat (2) @(posedge clk);
    chk_pu(3'b100);
    wr(UFESC_PUTEST_ADDR, 16'h0000);
    @(posedge clk);
    chk_pu(3'b110);
  endtask : t_pullup

  task automatic t_stall();
    wr(UFESC_MASK_ADDR, 16'h000f);
    wr(UFESC_EP0_ADDR, 16'hffff);
    rd(UFESC_EP0_ADDR, 16'h0080);
    tok(UFESC_TOK_IN, 4'h0, 1'b1);
    chk({15'h0000, irq}, 16'h0001);
    rd(UFESC_STAT_ADDR, 16'h0005);
    chk({15'h0000, irq}, 16'h0000);
    tok(UFESC_TOK_OUT, 4'h7, 1'b1);
    rd(UFESC_STAT_ADDR, 16'h0006);
    tok(UFESC_TOK_SETUP, 4'h0, 1'b0);
    rd(UFESC_STAT_ADDR, 16'h0008);
    wr(UFESC_MASK_ADDR, 16'h0000);
    tok(UFESC_TOK_IN, 4'h3, 1'b1);
    chk({15'h0000, irq}, 16'h0000);
    rd(UFESC_STAT_ADDR, 16'h0005);
    @(posedge clk);
    tx_en <= 1'b0;
    tok(UFESC_TOK_IN, 4'h0, 1'b0);
    @(posedge clk);
    rx_en <= 1'b0;
    tok(UFESC_TOK_OUT, 4'h0, 1'b0);
    wr(UFESC_EP0_ADDR, 16'h0000);
    @(posedge clk);
    tx_en <= 1'b1;
    tok(UFESC_TOK_IN, 4'h0, 1'b0);
  endtask : t_stall

  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {rst_n, wr_en, rd_en, go, npu} = '0;
    {addr, wr_data, frame_number, delay} = '0;
    kind      = UFESC_TOK_OUT;
    tx_en     = 1'b1;
    rx_en     = 1'b1;
    err_count = 0;
    n_checks  = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    npu <= 3'b001;
    t_frame();
    t_pullup();
    t_stall();
    wrap_up();
  end

  initial begin
    #100000;
    err_count++;
    wrap_up();
  end
endmodule : testbench
